//--- inc/bsr_regs.vh
// Constants for the boundary-scan instruction and test data registers
`ifndef BSR_REGS_VH
`define BSR_REGS_VH

// ----------------------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------------------
`define BSR_IR_W 3
`define BSR_IR_EXTEST 3'h0
`define BSR_IR_IDCODE 3'h1
`define BSR_IR_SAMPLE 3'h2
`define BSR_IR_CLAMP 3'h3
`define BSR_IR_HIGHZ 3'h4
`define BSR_IR_BYPASS 3'h7
// Fixed pattern loaded in Capture-IR, low two bits 01
`define BSR_IR_CAPTURE 3'h1

// ----------------------------------------------------------------------------
// Identification code layout
// ----------------------------------------------------------------------------
`define BSR_ID_W 32
`define BSR_ID_REQ_BIT 0
`define BSR_ID_MAKER_LSB 1
`define BSR_ID_MAKER_MSB 11
`define BSR_ID_DEV_LSB 12
`define BSR_ID_DEV_MSB 27
`define BSR_ID_VER_LSB 28
`define BSR_ID_VER_MSB 31

// ----------------------------------------------------------------------------
// Boundary-scan register layout
// ----------------------------------------------------------------------------
`define BSR_PIN_W 8
`define BSR_BS_W 17
`define BSR_BS_IN_LSB 0
`define BSR_BS_OUT_LSB 8
`define BSR_BS_CTL_BIT 16
`define BSR_BS_RESET 17'h00000

`endif

//--- hw/bsr_sync.v
// Two-flip-flop synchroniser for inputs from outside the clock domain
module bsr_sync #(
  parameter W = 1
) (
  input wire clk, // System clock
  input wire rst_n, // Async reset, active low
  input wire [W-1:0] d, // Asynchronous inputs
  output reg [W-1:0] q // Synchronised outputs
);

  reg [W-1:0] meta_q;

  // ----------------------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------------------
  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // bsr_sync

//--- hw/bsr_bscan.v
// Boundary-scan register: shift path plus latched parallel output
`include "bsr_regs.vh"

module bsr_bscan (
  input wire clk, // System clock
  input wire rst_n, // Async reset, active low
  input wire capture, // One-cycle capture strobe
  input wire shift, // One-cycle shift strobe
  input wire update, // One-cycle update strobe
  input wire tdi, // Serial data in
  input wire [`BSR_BS_W-1:0] cap_val, // Values sampled in capture
  output wire so, // Serial out, LSB of shift path
  output reg [`BSR_BS_W-1:0] par_q // Latched parallel output
);

  reg [`BSR_BS_W-1:0] sr_q;

  assign so = sr_q[0];

  // ----------------------------------------------------------------------------
  // Shift path
  // ----------------------------------------------------------------------------
  // Capture samples cells, shift moves LSB first toward the output
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_q <= `BSR_BS_RESET;
    end else if (capture) begin
      sr_q <= cap_val;
    end else if (shift) begin
      sr_q <= {tdi, sr_q[`BSR_BS_W-1:1]};
    end
  end

  // ----------------------------------------------------------------------------
  // Parallel latch
  // ----------------------------------------------------------------------------
  // Only moves on update, so shifting never disturbs driven pins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      par_q <= `BSR_BS_RESET;
    end else if (update) begin
      par_q <= sr_q;
    end
  end

endmodule // bsr_bscan

//--- hw/bsr_top.v
// Boundary-scan TAP controller, instruction register and test data registers
`include "bsr_regs.vh"

// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------

module bsr_top #(
  parameter [3:0] ID_VERSION = 4'h3, // Arbitrary value
  parameter [15:0] ID_DEVICE = 16'h5a3c, // Arbitrary value
  parameter [10:0] ID_MAKER = 11'h2b5 // Arbitrary value
) (
  input wire REF_CLK, // System clock, 50 MHz
  input wire NRST, // Reset, active low
  input wire SCAN_CLOCK, // Test clock from tester
  input wire SCAN_MODE_SELECT, // Mode select from tester
  input wire SCAN_DATA_IN, // Serial data from tester
  input wire SCAN_RESET_N, // Test reset, active low
  output reg SCAN_DATA_OUT, // Serial data to tester
  output reg SCAN_DATA_OUT_OE, // High while data-out is driven
  input wire [`BSR_PIN_W-1:0] CORE_OUT, // System logic output values
  input wire CORE_OE, // System logic output enable
  output reg [`BSR_PIN_W-1:0] CORE_IN, // Pin values to system logic
  input wire [`BSR_PIN_W-1:0] PIN_IN, // Digital input pins
  output reg [`BSR_PIN_W-1:0] PIN_OUT, // Digital output pins
  output reg PIN_OE, // Output pins enable, high drives
  output reg [`BSR_IR_W-1:0] CUR_INSTR, // Current instruction
  output reg [`BSR_ID_W-1:0] ID_PARALLEL // Identification latched output
);

  // ----------------------------------------------------------------------------
  // TAP states, one-hot
  // ----------------------------------------------------------------------------
  localparam [15:0] ST_TLR = 16'h0001;
  localparam [15:0] ST_RTI = 16'h0002;
  localparam [15:0] ST_SEL_DR = 16'h0004;
  localparam [15:0] ST_CAP_DR = 16'h0008;
  localparam [15:0] ST_SH_DR = 16'h0010;
  localparam [15:0] ST_EX1_DR = 16'h0020;
  localparam [15:0] ST_PA_DR = 16'h0040;
  localparam [15:0] ST_EX2_DR = 16'h0080;
  localparam [15:0] ST_UP_DR = 16'h0100;
  localparam [15:0] ST_SEL_IR = 16'h0200;
  localparam [15:0] ST_CAP_IR = 16'h0400;
  localparam [15:0] ST_SH_IR = 16'h0800;
  localparam [15:0] ST_EX1_IR = 16'h1000;
  localparam [15:0] ST_PA_IR = 16'h2000;
  localparam [15:0] ST_EX2_IR = 16'h4000;
  localparam [15:0] ST_UP_IR = 16'h8000;

  // ----------------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------------
  // Next TAP state from current state and mode select
  function [15:0] tap_next;
    input [15:0] s;
    input tms;
    begin
      case (s)
        ST_TLR: tap_next = tms ? ST_TLR : ST_RTI;
        ST_RTI: tap_next = tms ? ST_SEL_DR : ST_RTI;
        ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: tap_next = tms ? ST_UP_DR : ST_PA_DR;
        ST_PA_DR: tap_next = tms ? ST_EX2_DR : ST_PA_DR;
        ST_EX2_DR: tap_next = tms ? ST_UP_DR : ST_SH_DR;
        ST_UP_DR: tap_next = tms ? ST_SEL_DR : ST_RTI;
        ST_SEL_IR: tap_next = tms ? ST_TLR : ST_CAP_IR;
        ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: tap_next = tms ? ST_UP_IR : ST_PA_IR;
        ST_PA_IR: tap_next = tms ? ST_EX2_IR : ST_PA_IR;
        ST_EX2_IR: tap_next = tms ? ST_UP_IR : ST_SH_IR;
        ST_UP_IR: tap_next = tms ? ST_SEL_DR : ST_RTI;
        default: tap_next = ST_TLR;
      endcase
    end
  endfunction

  // Boundary register selected by EXTEST and SAMPLE/PRELOAD
  function sel_bs;
    input [`BSR_IR_W-1:0] ir;
    begin
      sel_bs = (ir == `BSR_IR_EXTEST) || (ir == `BSR_IR_SAMPLE);
    end
  endfunction

  // Identification register selected by IDCODE
  function sel_id;
    input [`BSR_IR_W-1:0] ir;
    begin
      sel_id = (ir == `BSR_IR_IDCODE);
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------------
  reg [1:0] rst_sync_q;
  reg [1:0] trst_sync_q;
  wire rst_n;
  wire tap_rst_n;
  wire trst_src_n;
  wire [2:0] scan_s;
  wire sclk_s;
  wire tms_s;
  wire tdi_s;
  wire [`BSR_PIN_W-1:0] pin_in_s;
  reg sclk_prev_q;
  wire rise;
  wire fall;
  reg [15:0] state_q;
  wire [15:0] state_d;
  reg [`BSR_IR_W-1:0] ir_sr_q;
  reg [`BSR_ID_W-1:0] id_sr_q;
  reg bypass_q;
  wire [`BSR_ID_W-1:0] id_value;
  wire bs_cap;
  wire bs_shift;
  wire bs_upd;
  wire bs_so;
  wire [`BSR_BS_W-1:0] bs_cap_val;
  wire [`BSR_BS_W-1:0] bs_par;
  reg dr_so;
  reg [`BSR_PIN_W-1:0] drv_out;
  reg drv_oe;

  // ----------------------------------------------------------------------------
  // Resets
  // ----------------------------------------------------------------------------
  // System reset: async assert, release through two flip-flops
  always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // Test reset asserts at once, even mid-shift, and releases cleanly
  assign trst_src_n = NRST & SCAN_RESET_N;

  always @(posedge REF_CLK or negedge trst_src_n) begin
    if (!trst_src_n) begin
      trst_sync_q <= 2'h0;
    end else begin
      trst_sync_q <= {trst_sync_q[0], 1'b1};
    end
  end

  assign tap_rst_n = trst_sync_q[1];

  // ----------------------------------------------------------------------------
  // Input synchronisers and test clock edges
  // ----------------------------------------------------------------------------
  // Clock, mode select and data share one chain so they stay aligned
  bsr_sync #(.W(3)) u_scan_sync (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .d({SCAN_DATA_IN, SCAN_MODE_SELECT, SCAN_CLOCK}),
    .q(scan_s)
  );

  bsr_sync #(.W(`BSR_PIN_W)) u_pin_sync (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .d(PIN_IN),
    .q(pin_in_s)
  );

  assign sclk_s = scan_s[0];
  assign tms_s = scan_s[1];
  assign tdi_s = scan_s[2];

  // Edge detect on the synchronised test clock
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  assign rise = sclk_s & ~sclk_prev_q;
  assign fall = ~sclk_s & sclk_prev_q;

  // ----------------------------------------------------------------------------
  // TAP controller
  // ----------------------------------------------------------------------------
  assign state_d = tap_next(state_q, tms_s);

  // Mode select is taken only on a rising test clock edge
  always @(posedge REF_CLK or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state_q <= ST_TLR;
    end else if (rise) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------------------
  // Shift stage: capture fixed pattern, shift toward data-out
  always @(posedge REF_CLK or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_sr_q <= `BSR_IR_CAPTURE;
    end else if (rise && state_q == ST_CAP_IR) begin
      ir_sr_q <= `BSR_IR_CAPTURE;
    end else if (rise && state_q == ST_SH_IR) begin
      ir_sr_q <= {tdi_s, ir_sr_q[`BSR_IR_W-1:1]};
    end
  end

  // Current instruction changes on the falling edge in Update-IR, and returns to IDCODE in Test-Logic-Reset
  always @(posedge REF_CLK or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      CUR_INSTR <= `BSR_IR_IDCODE;
    end else if (state_q == ST_TLR) begin
      CUR_INSTR <= `BSR_IR_IDCODE;
    end else if (fall && state_q == ST_UP_IR) begin
      CUR_INSTR <= ir_sr_q;
    end
  end

  // ----------------------------------------------------------------------------
  // Identification register
  // ----------------------------------------------------------------------------
  // Version, device, maker, and the mandatory one in bit 0
  assign id_value = {ID_VERSION, ID_DEVICE, ID_MAKER, 1'b1};

  // Capture loads the code, shift sends it out LSB first
  always @(posedge REF_CLK or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      id_sr_q <= {`BSR_ID_W{1'b0}};
    end else if (rise && state_q == ST_CAP_DR && sel_id(CUR_INSTR)) begin
      id_sr_q <= id_value;
    end else if (rise && state_q == ST_SH_DR && sel_id(CUR_INSTR)) begin
      id_sr_q <= {tdi_s, id_sr_q[`BSR_ID_W-1:1]};
    end
  end

  // Latched output, held steady while the shift stage moves
  always @(posedge REF_CLK or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ID_PARALLEL <= {ID_VERSION, ID_DEVICE, ID_MAKER, 1'b1};
    end else if (fall && state_q == ST_UP_DR && sel_id(CUR_INSTR)) begin
      ID_PARALLEL <= id_sr_q;
    end
  end

  // ----------------------------------------------------------------------------
  // Bypass stage
  // ----------------------------------------------------------------------------
  // Any code that is neither boundary nor identification lands here
  always @(posedge REF_CLK or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      bypass_q <= 1'b0;
    end else if (rise && state_q == ST_CAP_DR) begin
      bypass_q <= 1'b0;
    end else if (rise && state_q == ST_SH_DR) begin
      bypass_q <= tdi_s;
    end
  end

  // ----------------------------------------------------------------------------
  // Boundary-scan register
  // ----------------------------------------------------------------------------
  // Capture sees what is really on the pins, control cell on top
  assign bs_cap_val = {PIN_OE, PIN_OUT, pin_in_s};
  assign bs_cap = rise && state_q == ST_CAP_DR && sel_bs(CUR_INSTR);
  assign bs_shift = rise && state_q == ST_SH_DR && sel_bs(CUR_INSTR);
  assign bs_upd = fall && state_q == ST_UP_DR && sel_bs(CUR_INSTR);

  bsr_bscan u_bscan (
    .clk(REF_CLK),
    .rst_n(tap_rst_n),
    .capture(bs_cap),
    .shift(bs_shift),
    .update(bs_upd),
    .tdi(tdi_s),
    .cap_val(bs_cap_val),
    .so(bs_so),
    .par_q(bs_par)
  );

  // ----------------------------------------------------------------------------
  // Data-out multiplexer
  // ----------------------------------------------------------------------------
  // Serial output of whichever data register is selected
  always @* begin
    if (sel_bs(CUR_INSTR)) begin
      dr_so = bs_so;
    end else if (sel_id(CUR_INSTR)) begin
      dr_so = id_sr_q[0];
    end else begin
      dr_so = bypass_q;
    end
  end

  // Data-out moves on the falling edge so the tester samples on the rise
  always @(posedge REF_CLK or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      SCAN_DATA_OUT <= 1'b0;
      SCAN_DATA_OUT_OE <= 1'b0;
    end else if (fall) begin
      if (state_q == ST_SH_IR) begin
        SCAN_DATA_OUT <= ir_sr_q[0];
        SCAN_DATA_OUT_OE <= 1'b1;
      end else if (state_q == ST_SH_DR) begin
        SCAN_DATA_OUT <= dr_so;
        SCAN_DATA_OUT_OE <= 1'b1;
      end else begin
        SCAN_DATA_OUT_OE <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------------
  // EXTEST, CLAMP and HIGHZ take over the pins; all others leave the core in charge
  always @* begin
    if (CUR_INSTR == `BSR_IR_HIGHZ) begin
      drv_out = CORE_OUT;
      drv_oe = 1'b0;
    end else if (CUR_INSTR == `BSR_IR_EXTEST || CUR_INSTR == `BSR_IR_CLAMP) begin
      drv_out = bs_par[`BSR_BS_OUT_LSB +: `BSR_PIN_W];
      drv_oe = bs_par[`BSR_BS_CTL_BIT];
    end else begin
      drv_out = CORE_OUT;
      drv_oe = CORE_OE;
    end
  end

  // Registered pins; the core keeps running under every instruction
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PIN_OUT <= {`BSR_PIN_W{1'b0}};
      PIN_OE <= 1'b0;
      CORE_IN <= {`BSR_PIN_W{1'b0}};
    end else begin
      PIN_OUT <= drv_out;
      PIN_OE <= drv_oe;
      CORE_IN <= pin_in_s;
    end
  end

endmodule // bsr_top

//--- verif/bsr_top_asserts.sv
// Concurrent checks on the boundary-scan block ports
`include "bsr_regs.vh"

module bsr_top_asserts #(
  parameter [3:0] ID_VERSION = 4'h3, // Arbitrary value
  parameter [15:0] ID_DEVICE = 16'h5a3c, // Arbitrary value
  parameter [10:0] ID_MAKER = 11'h2b5 // Arbitrary value
) (
  input wire REF_CLK, // System clock
  input wire NRST, // System reset, active low
  input wire SCAN_CLOCK, // Test clock pin
  input wire SCAN_RESET_N, // Test reset, active low
  input wire SCAN_DATA_OUT, // Serial data out
  input wire SCAN_DATA_OUT_OE, // Data-out enable
  input wire [`BSR_PIN_W-1:0] CORE_OUT, // Core output values
  input wire CORE_OE, // Core output enable
  input wire [`BSR_PIN_W-1:0] PIN_OUT, // Output pins
  input wire PIN_OE, // Output pin enable
  input wire [`BSR_IR_W-1:0] CUR_INSTR, // Current instruction
  input wire [`BSR_ID_W-1:0] ID_PARALLEL // Id latch
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID_CODE = {ID_VERSION, ID_DEVICE, ID_MAKER, 1'b1};
  logic [2:0] up_q;
  logic [2:0] up_d;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Cycles since system reset release; pin registers lag the internal reset copy
  assign up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) up_q <= 3'h0;
    else up_q <= up_d;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  // Test clock was high five cycles back and is low now: a fall went through
  sequence fall_done;
    $past(SCAN_CLOCK, 5) && !SCAN_CLOCK;
  endsequence
  sequence core_mode;
    (CUR_INSTR inside {3'h1, 3'h2, 3'h5, 3'h6, 3'h7}) && up_q == 3'h7;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Test-Logic-Reset forces the id code on a rise, so only that change is exempt
  a_ir_on_fall: assert property (
    disable iff (!NRST || !SCAN_RESET_N)
    $changed(CUR_INSTR) && CUR_INSTR != 3'h1 |-> fall_done)
    else $error("instruction changed away from a test clock fall");
  a_dout_on_fall: assert property (
    disable iff (!NRST || !SCAN_RESET_N) $changed(SCAN_DATA_OUT) |-> fall_done)
    else $error("data-out changed away from a test clock fall");
  a_oe_on_fall: assert property (
    disable iff (!NRST || !SCAN_RESET_N) $rose(SCAN_DATA_OUT_OE) |-> fall_done)
    else $error("data-out enable rose away from a test clock fall");
  a_trst_to_id: assert property (
    $fell(SCAN_RESET_N) |-> ##[1:3] (CUR_INSTR == 3'h1 && !SCAN_DATA_OUT_OE))
    else $error("test reset did not restore the id instruction");
  a_id_in_reset: assert property (
    (!SCAN_RESET_N)[*3] |-> ID_PARALLEL == ID_CODE)
    else $error("id latch wrong while in test reset");
  a_highz_off: assert property (
    (CUR_INSTR == 3'h4)[*2] |-> !PIN_OE)
    else $error("outputs driven under high impedance code");
  a_clamp_hold: assert property (
    (CUR_INSTR == 3'h3)[*3] |-> $stable(PIN_OUT) && $stable(PIN_OE))
    else $error("outputs moved under clamp code");
  a_core_pass: assert property (
    core_mode ##1 core_mode |-> PIN_OUT == $past(CORE_OUT) && PIN_OE == $past(CORE_OE))
    else $error("outputs do not follow the core");
endmodule // bsr_top_asserts

bind bsr_top bsr_top_asserts #(
  .ID_VERSION(ID_VERSION), .ID_DEVICE(ID_DEVICE), .ID_MAKER(ID_MAKER)
) u_bsr_top_asserts (
  .REF_CLK(REF_CLK), .NRST(NRST), .SCAN_CLOCK(SCAN_CLOCK), .SCAN_RESET_N(SCAN_RESET_N),
  .SCAN_DATA_OUT(SCAN_DATA_OUT), .SCAN_DATA_OUT_OE(SCAN_DATA_OUT_OE),
  .CORE_OUT(CORE_OUT), .CORE_OE(CORE_OE), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
  .CUR_INSTR(CUR_INSTR), .ID_PARALLEL(ID_PARALLEL)
);

//--- verif/bsr_tester.sv
// Behavioural boundary-scan tester driving the test port
module bsr_tester (
  input wire clk, // Paces the test clock
  input wire tdo, // Serial data from the block
  output logic tck, // Test clock, still between frames and left high after each cycle
  output logic tms, // Mode select
  output logic tdi, // Serial data to the block
  output logic trst_n // Test reset, active low
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Test clock and reset
  // ----------------------------------------
  // Idle levels at time zero
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end
  // One 160 ns test clock: low 5 cycles, high 3; tdo taken just before the rise
  task automatic cyc(input logic m, input logic d, output logic q);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (5) @(posedge clk);
    q = tdo;
    tck <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // Move without data; tdi toggles so a stale level is never mistaken for data
  task automatic step(input logic m);
    logic q;
    cyc(m, ~tdi, q);
  endtask
  // Test reset of 100 ns, possibly mid-shift; clock dropped meanwhile
  task automatic pulse_reset();
    tck <= 1'b0;
    trst_n <= 1'b0;
    repeat (5) @(posedge clk);
    trst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule // bsr_tester

//--- verif/tb_top.sv
// Self-checking bench for the boundary-scan instruction and data registers
`include "bsr_regs.vh"
`define CHK(name, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("ERROR %s expected %0h seen %0h", name, exp, got); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] ID_VER = 4'h6; // Arbitrary value
  localparam logic [15:0] ID_DEV = 16'hc3a5; // Arbitrary value
  localparam logic [10:0] ID_MKR = 11'h14e; // Arbitrary value
  localparam logic [31:0] ID_CODE = {ID_VER, ID_DEV, ID_MKR, 1'b1};
  localparam logic [31:0] BYP_IN = 32'hc3a51e69;
  logic ref_clk, nrst, tck, tms, tdi, trst_n, core_oe;
  logic [7:0] core_out, pin_in;
  wire tdo, tdo_oe, pin_oe;
  wire tdo_line;
  wire [7:0] core_in, pin_out;
  wire [2:0] cur_instr;
  wire [31:0] id_par;
  int err_total, tests_run;

  // ----------------------------------------
  // Block and tester
  // ----------------------------------------
  bsr_top #(.ID_VERSION(ID_VER), .ID_DEVICE(ID_DEV), .ID_MAKER(ID_MKR)) u_bsr_top (
    .REF_CLK(ref_clk), .NRST(nrst), .SCAN_CLOCK(tck), .SCAN_MODE_SELECT(tms),
    .SCAN_DATA_IN(tdi), .SCAN_RESET_N(trst_n), .SCAN_DATA_OUT(tdo),
    .SCAN_DATA_OUT_OE(tdo_oe), .CORE_OUT(core_out), .CORE_OE(core_oe), .CORE_IN(core_in),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .CUR_INSTR(cur_instr),
    .ID_PARALLEL(id_par));
  // Released data-out reads as the inverse, so a stale bit never passes as fresh
  assign tdo_line = tdo_oe ? tdo : ~tdo;
  bsr_tester u_bsr_tester (.clk(ref_clk), .tdo(tdo_line), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Scan helpers, each starting and ending in Run-Test-Idle
  // ----------------------------------------
  task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
    logic q;
    u_bsr_tester.step(1'b1);
    u_bsr_tester.step(1'b1);
    u_bsr_tester.step(1'b0);
    u_bsr_tester.step(1'b0);
    for (int i = 0; i < 3; i++) begin
      u_bsr_tester.cyc(i == 2, code[i], q);
      cap[i] = q;
    end
    u_bsr_tester.step(1'b1);
    u_bsr_tester.step(1'b0);
  endtask
  // Always 32 bits, so a short register returns capture then our own data
  task automatic scan_dr(input logic [31:0] din, output logic [31:0] dout);
    logic q;
    u_bsr_tester.step(1'b1);
    u_bsr_tester.step(1'b0);
    u_bsr_tester.step(1'b0);
    for (int i = 0; i < 32; i++) begin
      u_bsr_tester.cyc(i == 31, din[i], q);
      dout[i] = q;
    end
    u_bsr_tester.step(1'b1);
    u_bsr_tester.step(1'b0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_idcode();
    logic [31:0] got;
    `CHK("instr after reset", 3'h1, cur_instr)
    `CHK("id latch", ID_CODE, id_par)
    u_bsr_tester.step(1'b0);
    scan_dr(~ID_CODE, got);
    `CHK("id shifted", ID_CODE, got)
    `CHK("id first bits", 4'hd, got[3:0])
    `CHK("id version", ID_VER, got[31:28])
    `CHK("id maker", ID_MKR, got[11:1])
    `CHK("id latch updated", ~ID_CODE, id_par)
  endtask
  // Every code that puts the one-bit stage in the path, unassigned ones too
  task automatic t_bypass();
    logic [2:0] codes[5] = '{3'h7, 3'h3, 3'h4, 3'h5, 3'h6};
    logic [2:0] cap;
    logic [31:0] got;
    foreach (codes[k]) begin
      load_ir(codes[k], cap);
      `CHK("ir capture", 2'b01, cap[1:0])
      `CHK("instr", codes[k], cur_instr)
      scan_dr(BYP_IN, got);
      `CHK("bypass out", {BYP_IN[30:0], 1'b0}, got)
      if (codes[k] == 3'h4) `CHK("highz oe", 1'b0, pin_oe)
    end
    // Core keeps the pins under an unassigned code; inputs still reach it
    core_out <= 8'he1;
    core_oe <= 1'b0;
    pin_in <= 8'h96;
    repeat (4) @(posedge ref_clk);
    `CHK("core drive", 8'he1, pin_out)
    `CHK("core oe", 1'b0, pin_oe)
    `CHK("core in", 8'h96, core_in)
    core_out <= 8'h5a;
    core_oe <= 1'b1;
    pin_in <= 8'h3c;
  endtask
  task automatic t_boundary();
    logic [2:0] cap;
    logic [31:0] got;
    load_ir(3'h2, cap);
    scan_dr({1'b1, 8'ha5, 8'hc3, 15'h0}, got);
    `CHK("sample capture", {1'b1, 8'h5a, 8'h3c}, got[16:0])
    `CHK("sample keeps core", 8'h5a, pin_out)
    load_ir(3'h0, cap);
    `CHK("extest drive", 8'ha5, pin_out)
    core_out <= 8'h0f;
    pin_in <= 8'h69;
    scan_dr({1'b1, 8'h96, 8'h00, 15'h0}, got);
    `CHK("extest capture", {1'b1, 8'ha5, 8'h69}, got[16:0])
    `CHK("extest update", 8'h96, pin_out)
    load_ir(3'h3, cap);
    scan_dr(32'h0, got);
    `CHK("clamp hold", 8'h96, pin_out)
    `CHK("clamp oe", 1'b1, pin_oe)
  endtask
  // Test reset in mid-shift of a bypass scan
  task automatic t_trst();
    logic [2:0] cap;
    logic q;
    load_ir(3'h7, cap);
    // Five highs reach Test-Logic-Reset from any state
    repeat (5) u_bsr_tester.step(1'b1);
    `CHK("instr in tlr", 3'h1, cur_instr)
    u_bsr_tester.step(1'b0);
    load_ir(3'h7, cap);
    u_bsr_tester.step(1'b1);
    u_bsr_tester.step(1'b0);
    u_bsr_tester.step(1'b0);
    u_bsr_tester.cyc(1'b0, 1'b1, q);
    `CHK("oe in shift", 1'b1, tdo_oe)
    u_bsr_tester.pulse_reset();
    `CHK("instr after trst", 3'h1, cur_instr)
    `CHK("oe after trst", 1'b0, tdo_oe)
    `CHK("id after trst", ID_CODE, id_par)
  endtask

  // ----------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------
  task automatic give_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    core_out = 8'h5a;
    core_oe = 1'b1;
    pin_in = 8'h3c;
    err_total = 0;
    tests_run = 0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    t_idcode();
    t_bypass();
    t_boundary();
    t_trst();
    give_verdict();
  end
  // About 500 test clocks of 160 ns are needed; five times that is ample
  initial begin
    #400us;
    err_total++;
    give_verdict();
  end
endmodule // tb_top
